// ### verilog/rdtc_map.vh
// rdtc_map.vh: register offsets, control field positions, reset values
// assumes word-aligned accesses on the controller's internal bus
`ifndef RDTC_MAP_VH
`define RDTC_MAP_VH
`define RDTC_OFS_COUNT 8'h00
`define RDTC_OFS_RELOAD 8'h04
`define RDTC_OFS_CONTROL 8'h08
`define RDTC_BIT_ENABLE 0
`define RDTC_BIT_AUTO 1
`define RDTC_BIT_START 2
`define RDTC_BIT_HWHALT_EN 3
`define RDTC_BIT_FWHALT 4
`define RDTC_CTRL_WIDTH 5
`define RDTC_CTRL_RESET 5'h00
`define RDTC_COUNT_RESET 32'h0000_0000
`define RDTC_RELOAD_RESET 32'h0000_0000
`endif

// ### verilog/rdtc_edge_det.v
// rdtc_edge_det.v: falling edge detector of one level
// assumes the level is synchronous to clk_i
`timescale 1ns/10ps
module rdtc_edge_det (
  input wire clk_i,
  input wire nrst_i,
  input wire level_i,
  output wire fall_o
);
  reg level_reg;
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_i;
    end
  end
  assign fall_o = level_reg & ~level_i;
endmodule // rdtc_edge_det

// ### verilog/rdtc_timer.v
// rdtc_timer.v: 32-bit down-counting tick timer with control register
// assumes synchronous bus strobes on clk_i, word accesses only
`timescale 1ns/10ps
`include "rdtc_map.vh"
module rdtc_timer #(
  parameter WIDTH = 32
) (
  input wire clk_i,
  input wire nrst_i,
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] wdata_i,
  input wire halt_i,
  output reg [31:0] rdata_o,
  output wire irq_o,
  output wire [WIDTH-1:0] current_count_o,
  output wire running_o
);
  ////////////////////////////////////////////////////////////////////////////
  reg [`RDTC_CTRL_WIDTH-1:0] ctrl_reg;
  reg [`RDTC_CTRL_WIDTH-1:0] ctrl_next;
  reg [WIDTH-1:0] count_reg;
  reg [WIDTH-1:0] count_next;
  reg [WIDTH-1:0] reload_reg;
  reg [WIDTH-1:0] reload_next;
  reg irq_reg;
  reg irq_next;
  reg [31:0] rdata_next;
  wire enable_fall;
  wire wr_ctrl;
  wire start_set;
  wire start_clr;
  wire halted;
  wire active;
  wire wr_reload;
  wire fw_keeps_clear;
  wire fw_halt;
  wire hw_halt;
  wire run_step;
  wire reload_zero;
  wire at_one;
  wire at_zero;
  wire auto_mode;
  wire expire;
  wire reload_now;
  wire stop_at_one;
  wire stop_at_zero;
  wire hw_stop;
  wire decrement;
  localparam [WIDTH-1:0] COUNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  // enable falling edge
  rdtc_edge_det rdtc_edge_det_inst (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .level_i(ctrl_reg[`RDTC_BIT_ENABLE]),
    .fall_o(enable_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_ctrl = wr_i && (addr_i == `RDTC_OFS_CONTROL);
  assign wr_reload = wr_i && (addr_i == `RDTC_OFS_RELOAD);
  assign start_set = wr_ctrl && wdata_i[`RDTC_BIT_START] && !ctrl_reg[`RDTC_BIT_START];
  assign start_clr = wr_ctrl && !wdata_i[`RDTC_BIT_START] && ctrl_reg[`RDTC_BIT_START];
  assign fw_keeps_clear = wr_ctrl && !wdata_i[`RDTC_BIT_START];

  ////////////////////////////////////////////////////////////////////////////
  // count status
  assign fw_halt = ctrl_reg[`RDTC_BIT_FWHALT];
  assign hw_halt = ctrl_reg[`RDTC_BIT_HWHALT_EN] && halt_i;
  assign halted = fw_halt || hw_halt;
  assign active = ctrl_reg[`RDTC_BIT_ENABLE] && ctrl_reg[`RDTC_BIT_START] && !halted;
  assign run_step = active && !start_clr;
  assign reload_zero = (reload_reg == {WIDTH{1'b0}});
  assign at_one = (count_reg == COUNT_ONE);
  assign at_zero = (count_reg == {WIDTH{1'b0}});
  assign auto_mode = ctrl_reg[`RDTC_BIT_AUTO];
  assign expire = run_step && at_one;
  assign reload_now = run_step && auto_mode && !reload_zero && (at_one || at_zero);
  assign stop_at_one = expire && !(auto_mode && !reload_zero) && !fw_keeps_clear;
  assign stop_at_zero = run_step && at_zero && (reload_zero || !auto_mode);
  assign hw_stop = stop_at_one || stop_at_zero;
  assign decrement = run_step && !at_one && !at_zero;

  ////////////////////////////////////////////////////////////////////////////
  // control next value
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata_i[`RDTC_CTRL_WIDTH-1:0];
    end
    if (start_set && reload_zero) begin
      ctrl_next[`RDTC_BIT_START] = 1'b0;
    end
    if (hw_stop) begin
      ctrl_next[`RDTC_BIT_START] = 1'b0;
    end
    if (enable_fall) begin
      ctrl_next = `RDTC_CTRL_RESET;
    end
  end

  // count next value
  always @* begin
    count_next = count_reg;
    if (enable_fall) begin
      count_next = `RDTC_COUNT_RESET;
    end else if (start_set) begin
      count_next = reload_reg;
    end else if (start_clr) begin
      count_next = {WIDTH{1'b0}};
    end else if (reload_now) begin
      count_next = reload_reg;
    end else if (expire) begin
      count_next = {WIDTH{1'b0}};
    end else if (decrement) begin
      count_next = count_reg - COUNT_ONE;
    end
  end

  // reload next value
  always @* begin
    reload_next = reload_reg;
    if (wr_reload) begin
      reload_next = wdata_i[WIDTH-1:0];
    end
    if (enable_fall) begin
      reload_next = `RDTC_RELOAD_RESET;
    end
  end

  // interrupt pulse
  always @* begin
    irq_next = expire && !enable_fall;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered below
  always @* begin
    rdata_next = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `RDTC_OFS_COUNT: rdata_next[WIDTH-1:0] = count_reg;
        `RDTC_OFS_RELOAD: rdata_next[WIDTH-1:0] = reload_reg;
        `RDTC_OFS_CONTROL: rdata_next[`RDTC_CTRL_WIDTH-1:0] = ctrl_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // control register
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_reg <= `RDTC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // count register
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      count_reg <= `RDTC_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // reload register
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      reload_reg <= `RDTC_RELOAD_RESET;
    end else begin
      reload_reg <= reload_next;
    end
  end

  // interrupt register
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // read data register
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // outputs
  assign irq_o = irq_reg;
  assign current_count_o = count_reg;
  assign running_o = ctrl_reg[`RDTC_BIT_START];
endmodule // rdtc_timer

// ### test/rdtc_timer_sva.sv
// checker of the timer ports
// assumes it is bound onto every rdtc_timer
`timescale 1ns/10ps
module rdtc_chk #(parameter WIDTH = 32) (
  input wire clk_i, input wire nrst_i, input wire [7:0] addr_i, input wire wr_i, input wire rd_i,
  input wire [31:0] wdata_i, input wire halt_i, input wire [31:0] rdata_o, input wire irq_o,
  input wire [WIDTH-1:0] current_count_o, input wire running_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_irq_from_one: assert property (irq_o |-> $past(current_count_o) == 1) else $error("irq");
  a_step_one: assert property ($past(running_o) && running_o && !$past(wr_i) &&
    current_count_o < $past(current_count_o) |-> current_count_o == $past(current_count_o) - 1) else $error("step");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 0) else $error("rdata");
  a_resv_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h08 |-> rdata_o[31:5] == 0) else $error("resv");
  a_clr_no_irq: assert property ($past(wr_i) && $past(addr_i) == 8'h08 && !$past(wdata_i[2]) &&
    $past(current_count_o) > 1 |-> !irq_o) else $error("irq on clear");
  a_oneshot_end: assert property (irq_o && current_count_o == 0 |-> !running_o) else $error("start");
  a_auto_keep: assert property (irq_o && current_count_o != 0 |-> running_o) else $error("auto");
  a_idle_zero: assert property (!running_o |-> current_count_o == 0) else $error("idle");
  c_irq: cover property (irq_o);
  c_auto: cover property (irq_o && running_o);
  c_stop: cover property ($fell(running_o));
endmodule // rdtc_chk
bind rdtc_timer rdtc_chk #(.WIDTH(WIDTH)) rdtc_chk_inst (.*);

// ### test/rdtc_timer_tb_top.sv
// bench of the tick timer
// assumes rdtc_timer and its checker are compiled first
`timescale 1ns/10ps
module rdtc_timer_tb_top;
  reg clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, halt_i = 0;
  reg [7:0] addr_i = 0;
  reg [31:0] wdata_i = 0;
  wire [31:0] rdata_o, cnt;
  wire irq_o, run;
  int err_total = 0, n_compared = 0, cyc = 0, i;
  // reload, control, halt, wait, count, start
  reg [31:0] rows [6][6] = '{'{5, 5, 0, 2, 3, 1}, '{3, 5, 0, 3, 0, 0}, '{3, 7, 0, 3, 3, 1},
    '{4, 21, 0, 2, 4, 1}, '{4, 13, 1, 2, 4, 1}, '{4, 5, 1, 2, 2, 1}};
  always #25 clk_i = ~clk_i;
  rdtc_timer rdtc_timer_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .halt_i(halt_i), .rdata_o(rdata_o), .irq_o(irq_o), .current_count_o(cnt), .running_o(run));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    rd_i = 0;
    addr_i = a;
    wdata_i = d;
    wr_i = 1;
    @(negedge clk_i);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    wr_i = 0;
    addr_i = a;
    rd_i = 1;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask
  task idle(input int n);
    wr_i = 0;
    rd_i = 0;
    repeat (n) @(negedge clk_i);
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 3000) begin
    err_total++;
    end_of_test;
  end
  initial begin
    repeat (5) @(negedge clk_i);
    nrst_i = 1;
    for (i = 0; i < 6; i++) begin
      halt_i = rows[i][2][0];
      wr(8'h04, rows[i][0]);
      wr(8'h08, rows[i][1]);
      idle(rows[i][3]);
      chk(cnt, rows[i][4]);
      chk({31'b0, run}, rows[i][5]);
      wr(8'h08, 0);
      idle(3);
    end
    halt_i = 0;
    wr(8'h08, 32'hFFFF_FFE2);
    rd(8'h08, 32'h0000_0002);
    rd(8'h0C, 0);
    wr(8'h04, 6);
    rd(8'h04, 6);
    wr(8'h08, 3);
    wr(8'h08, 0);
    idle(3);
    rd(8'h04, 0);
    wr(8'h04, 0);
    wr(8'h08, 5);
    chk({31'b0, run}, 0);
    wr(8'h04, 9);
    wr(8'h08, 5);
    idle(2);
    chk(cnt, 7);
    wr(8'h08, 1);
    chk(cnt, 0);
    chk({31'b0, irq_o}, 0);
    wr(8'h04, 2);
    wr(8'h08, 7);
    wr(8'h04, 5);
    idle(1);
    chk(cnt, 5);
    chk({31'b0, irq_o}, 1);
    idle(1);
    chk(cnt, 4);
    chk({31'b0, irq_o}, 0);
    nrst_i = 0;
    idle(1);
    nrst_i = 1;
    chk(cnt, 0);
    rd(8'h08, 0);
    end_of_test;
  end
endmodule // rdtc_timer_tb_top
